// ---- core/flash_program_erase_ctrl.sv ----
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_program_erase_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int OP_CYCLES = (`OP_TIME_NS + `CLK_NS - 1) / `CLK_NS
)
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Device state from option loader and system
  input  wire logic        READ_PROTECT,
  input  wire logic [31:0] WRITE_PROTECT,
  input  wire logic [31:0] OPTION_STATUS,
  input  wire logic        UNTRUSTED_SOURCE,
  input  wire logic        PROTECT_REMOVE,
  input  wire logic        WAKE_EVENT,
  input  wire logic        FAST_WAKE,
  // Array side and interrupt
  output logic      [3:0]  ARRAY_OP,
  output logic             ARRAY_GO,
  output logic      [31:0] ARRAY_ADDR,
  output logic      [1:0]  WAIT_STATES,
  output logic             IRQ
);

  initial
  begin
    if (OP_CYCLES < 2 || OP_CYCLES > 65535)
      $error("OP_CYCLES out of range");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [1:0]  wait_state_count;
  logic [31:0] target_address;
  logic [31:0] control;
  logic        busy_flag;
  logic        protect_violation_flag;
  logic        operation_done_flag;
  logic        wakeup_status;
  logic        ckey_half;
  logic        ckey_dead;
  logic        okey_half;
  logic        fkey_half;
  logic        fkey_dead;
  logic [15:0] timer;
  seq_t        seq;
  op_t         cur_op;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire access_ph = PSEL & PENABLE;
  wire wr_now = access_ph & PREADY & PWRITE;
  wire hit_acc = PADDR == `ADR_ACCESS;
  wire hit_ckey = PADDR == `ADR_CKEY;
  wire hit_okey = PADDR == `ADR_OKEY;
  wire hit_stat = PADDR == `ADR_STATUS;
  wire hit_ctrl = PADDR == `ADR_CONTROL;
  wire hit_tadr = PADDR == `ADR_TADDR;
  wire hit_obs = PADDR == `ADR_OBSTAT;
  wire hit_wps = PADDR == `ADR_WPSTAT;
  wire hit_fkey = PADDR == `ADR_FKEY;
  wire mapped = hit_acc | hit_ckey | hit_okey | hit_stat | hit_ctrl |
                hit_tadr | hit_obs | hit_wps | hit_fkey;
  wire lock = control[`CT_LOCK];
  wire fast_mode_lock = control[`CT_FAST_MODE_LOCK];

  // Key word checks
  wire is_k1 = PWDATA == `KEY_FIRST;
  wire is_k2 = PWDATA == `KEY_SECOND;
  wire ckey_wr = wr_now & hit_ckey;
  wire ckey_ok = ckey_wr & ~ckey_dead & lock & ckey_half & is_k2;
  wire ckey_bad = ckey_wr & (ckey_dead | ~(ckey_half ? is_k2 : is_k1));
  wire fkey_wr = wr_now & hit_fkey;
  wire fkey_ok = fkey_wr & ~fkey_dead & fkey_half & is_k2;
  wire fkey_bad = fkey_wr & (fkey_dead | ~(fkey_half ? is_k2 : is_k1));
  wire okey_wr = wr_now & hit_okey & ~lock;
  wire okey_ok = okey_wr & okey_half & is_k2;

  // Bus error on wrong-key or locked-out CKEY writes and unmapped addresses
  wire ckey_wrong = ckey_dead | ~(ckey_half ? is_k2 : is_k1);
  wire bus_err = ~mapped | (hit_ckey & PWRITE & ckey_wrong);

  // ----------------------------------------
  // Protection and start decode
  // ----------------------------------------
  wire [4:0] unit = target_address[`UNIT_MSB:`UNIT_LSB];
  wire unit_prot = ~WRITE_PROTECT[unit] |
                   (READ_PROTECT & (unit == 5'h00));
  wire ctl_wr = wr_now & hit_ctrl & ~lock;
  wire start_trigger_req = ctl_wr & PWDATA[`CT_START_TRIGGER] & ~busy_flag;

  function automatic op_t pick_op(input logic [31:0] c);
    if (c[`CT_MER]) return OP_MASS;
    if (c[`CT_BLOCK_ERASE_32K]) return OP_BLK32;
    if (c[`CT_PER]) return OP_PAGE;
    if (c[`CT_FER]) return OP_FERASE;
    if (c[`CT_OPTION_AREA_ERASE]) return OP_OPTER;
    if (c[`CT_FPG]) return OP_FPROG;
    if (c[`CT_BFILL]) return OP_BFILL;
    if (c[`CT_BCLR]) return OP_BCLR;
    return OP_NONE;
  endfunction

  wire op_t req_op = pick_op(PWDATA);
  wire fast_op = req_op inside {OP_BLK32, OP_FERASE, OP_FPROG, OP_BFILL, OP_BCLR};
  wire main_op = req_op inside {OP_BLK32, OP_PAGE, OP_FERASE, OP_FPROG};
  wire blocked_fast = fast_op & fast_mode_lock;
  wire blocked_opt = (req_op == OP_OPTER) & ~control[`CT_OBWE];
  wire blocked_src = READ_PROTECT & UNTRUSTED_SOURCE & main_op;
  wire prot_hit = main_op & unit_prot;
  wire go_ok = start_trigger_req & (req_op != OP_NONE) & ~blocked_fast &
               ~blocked_opt & ~blocked_src & ~prot_hit;
  wire go_err = start_trigger_req & (blocked_src | (prot_hit & ~blocked_fast));
  wire auto_mass = PROTECT_REMOVE & ~busy_flag;
  wire launch = go_ok | auto_mass;
  wire finish = (seq == ST_RUN) & (timer == 16'h0001);

  // ----------------------------------------
  // APB answer: one wait cycle, then ready
  // ----------------------------------------
  logic [31:0] rd_mux;
  assign rd_mux = hit_acc ? {30'h0, wait_state_count} :
                  hit_stat ? {24'h0, FAST_WAKE, wakeup_status,
                              operation_done_flag, protect_violation_flag,
                              3'h0, busy_flag} :
                  hit_ctrl ? control :
                  hit_tadr ? target_address :
                  hit_obs ? OPTION_STATUS :
                  hit_wps ? WRITE_PROTECT : 32'h0;

  // Ready, read data and error on the second access cycle
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= access_ph & ~PREADY;
      PRDATA <= (access_ph & ~PREADY & ~PWRITE) ? rd_mux : 32'h0;
      PSLVERR <= access_ph & ~PREADY & bus_err;
    end
  end

  // ----------------------------------------
  // Access and address registers
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      wait_state_count <= 2'h0;
      target_address <= 32'h0;
    end
    else
    begin
      if (wr_now & hit_acc & (PWDATA[1:0] != `WS_BAD))
        wait_state_count <= PWDATA[1:0];
      if (wr_now & hit_tadr & ~busy_flag)
        target_address <= PWDATA;
    end
  end

  // ----------------------------------------
  // Key sequencers
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      ckey_half <= 1'b0;
      ckey_dead <= 1'b0;
      okey_half <= 1'b0;
      fkey_half <= 1'b0;
      fkey_dead <= 1'b0;
    end
    else
    begin
      if (ckey_wr)
        ckey_half <= ~ckey_half & ~ckey_bad;
      if (ckey_bad)
        ckey_dead <= 1'b1;
      if (okey_wr)
        okey_half <= ~okey_half & is_k1;
      if (fkey_wr)
        fkey_half <= ~fkey_half & ~fkey_bad;
      if (fkey_bad)
        fkey_dead <= 1'b1;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic [31:0] next_control;
  always_comb
  begin
    next_control = control;
    if (ctl_wr)
    begin
      next_control[`CT_ERROR_IRQ_ENABLE] = PWDATA[`CT_ERROR_IRQ_ENABLE];
      next_control[`CT_DONEIE] = PWDATA[`CT_DONEIE];
      next_control[`CT_WAKEIE] = PWDATA[`CT_WAKEIE];
      if (!PWDATA[`CT_OBWE])
        next_control[`CT_OBWE] = 1'b0;
      if (PWDATA[`CT_FAST_MODE_LOCK])
        next_control[`CT_FAST_MODE_LOCK] = 1'b1;
      if (PWDATA[`CT_LOCK])
        next_control[`CT_LOCK] = 1'b1;
      if (!busy_flag)
      begin
        next_control[`CT_PER] = PWDATA[`CT_PER];
        next_control[`CT_MER] = PWDATA[`CT_MER];
        next_control[`CT_OPTION_AREA_ERASE] = PWDATA[`CT_OPTION_AREA_ERASE];
        next_control[`CT_FPG] = PWDATA[`CT_FPG];
        next_control[`CT_FER] = PWDATA[`CT_FER];
        next_control[`CT_BFILL] = PWDATA[`CT_BFILL];
        next_control[`CT_BCLR] = PWDATA[`CT_BCLR];
        next_control[`CT_BLOCK_ERASE_32K] = PWDATA[`CT_BLOCK_ERASE_32K];
      end
    end
    if (launch)
      next_control[`CT_START_TRIGGER] = 1'b1;
    else if (finish)
      next_control[`CT_START_TRIGGER] = 1'b0;
    if (ckey_ok)
      next_control[`CT_LOCK] = 1'b0;
    if (fkey_ok)
      next_control[`CT_FAST_MODE_LOCK] = 1'b0;
    if (okey_ok)
      next_control[`CT_OBWE] = 1'b1;
  end

  // Control register update
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
      control <= `CTRL_RESET;
    else
      control <= next_control;
  end

  // ----------------------------------------
  // Operation sequencer
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      seq <= ST_IDLE;
      timer <= 16'h0;
      cur_op <= OP_NONE;
      busy_flag <= 1'b0;
    end
    else
    begin
      case (seq)
        ST_IDLE:
        begin
          if (launch)
          begin
            seq <= ST_RUN;
            timer <= 16'(OP_CYCLES);
            cur_op <= auto_mass ? OP_MASS : req_op;
            busy_flag <= 1'b1;
          end
        end
        ST_RUN:
        begin
          timer <= timer - 16'h0001;
          if (finish)
          begin
            seq <= ST_IDLE;
            busy_flag <= 1'b0;
            cur_op <= OP_NONE;
          end
        end
        default:
          seq <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Status flags: set wins over clear
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      operation_done_flag <= 1'b0;
      protect_violation_flag <= 1'b0;
      wakeup_status <= 1'b0;
    end
    else
    begin
      if (finish)
        operation_done_flag <= 1'b1;
      else if (wr_now & hit_stat & PWDATA[`ST_DONE])
        operation_done_flag <= 1'b0;
      if (go_err)
        protect_violation_flag <= 1'b1;
      else if (wr_now & hit_stat & PWDATA[`ST_PERR])
        protect_violation_flag <= 1'b0;
      if (WAKE_EVENT)
        wakeup_status <= 1'b1;
      else if (wr_now & hit_stat & ~PWDATA[`ST_WAKE])
        wakeup_status <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs to array and interrupt
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      ARRAY_OP <= 4'h0;
      ARRAY_GO <= 1'b0;
      ARRAY_ADDR <= 32'h0;
      WAIT_STATES <= 2'h0;
      IRQ <= 1'b0;
    end
    else
    begin
      ARRAY_GO <= launch & (seq == ST_IDLE);
      ARRAY_OP <= launch ? (auto_mass ? OP_MASS : req_op) : cur_op;
      ARRAY_ADDR <= target_address;
      WAIT_STATES <= wait_state_count;
      IRQ <= (wakeup_status & control[`CT_WAKEIE]) |
             (operation_done_flag & control[`CT_DONEIE]) |
             (protect_violation_flag & control[`CT_ERROR_IRQ_ENABLE]);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_busy_span: assert property (@(posedge MCLK) disable iff (RESET)
    $rose(busy_flag) |-> busy_flag [*2])
    else $error("busy dropped early");

  a_done_after: assert property (@(posedge MCLK) disable iff (RESET)
    $fell(busy_flag) |-> operation_done_flag)
    else $error("done not set at end");

  a_start_clear: assert property (@(posedge MCLK) disable iff (RESET)
    $fell(busy_flag) |-> !control[`CT_START_TRIGGER])
    else $error("start not cleared");

  a_lock_sticks: assert property (@(posedge MCLK) disable iff (RESET)
    ckey_dead |-> ##1 (ckey_dead && !$fell(control[`CT_LOCK])))
    else $error("dead lock reopened");

  a_addr_hold: assert property (@(posedge MCLK) disable iff (RESET)
    busy_flag && !launch |=> $stable(target_address))
    else $error("address changed while busy");

  a_irq_done: assert property (@(posedge MCLK) disable iff (RESET)
    operation_done_flag && control[`CT_DONEIE] |=> IRQ)
    else $error("irq missing");

  a_prot_err: assert property (@(posedge MCLK) disable iff (RESET)
    go_err |=> protect_violation_flag && !busy_flag)
    else $error("protect error not flagged");

  a_fast_lock: assert property (@(posedge MCLK) disable iff (RESET)
    start_trigger_req && fast_op && fast_mode_lock |=> !busy_flag)
    else $error("fast op while locked");

  a_wait_valid: assert property (@(posedge MCLK) disable iff (RESET)
    WAIT_STATES != `WS_BAD)
    else $error("invalid wait state");

endmodule

// ---- inc/flash_ctrl_map.svh ----
// Register addresses, bit positions, keys and timing for the flash controller
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADR_ACCESS   32'h40022000
`define ADR_CKEY     32'h40022004
`define ADR_OKEY     32'h40022008
`define ADR_STATUS   32'h4002200C
`define ADR_CONTROL  32'h40022010
`define ADR_TADDR    32'h40022014
`define ADR_OBSTAT   32'h4002201C
`define ADR_WPSTAT   32'h40022020
`define ADR_FKEY     32'h40022024
// ----------------------------------------
// Keys, reset value and invalid wait-state code
// ----------------------------------------
`define KEY_FIRST    32'h45670123
`define KEY_SECOND   32'hCDEF89AB
`define CTRL_RESET   32'h00008080
`define WS_BAD       2'h3
// ----------------------------------------
// Status bits
// ----------------------------------------
`define ST_BUSY      0
`define ST_PERR      4
`define ST_DONE      5
`define ST_WAKE      6
`define ST_FWAKE     7
// ----------------------------------------
// Control bits
// ----------------------------------------
`define CT_PER       1
`define CT_MER       2
`define CT_OPTION_AREA_ERASE      5
`define CT_START_TRIGGER      6
`define CT_LOCK      7
`define CT_OBWE      9
`define CT_ERROR_IRQ_ENABLE     10
`define CT_DONEIE    12
`define CT_WAKEIE    13
`define CT_FAST_MODE_LOCK     15
`define CT_FPG       16
`define CT_FER       17
`define CT_BFILL     18
`define CT_BCLR      19
`define CT_BLOCK_ERASE_32K     23
// ----------------------------------------
// Address fields and timing
// ----------------------------------------
`define UNIT_LSB     11
`define UNIT_MSB     15
`define OP_TIME_NS   800
`define CLK_NS       50
`endif

// ---- inc/flash_ctrl_pkg.sv ----
// Types shared by the flash program/erase controller
package flash_ctrl_pkg;
  typedef enum logic [3:0] {OP_NONE, OP_MASS, OP_BLK32, OP_PAGE, OP_FERASE,
                            OP_OPTER, OP_FPROG, OP_BFILL, OP_BCLR} op_t;
  typedef enum {ST_IDLE, ST_RUN} seq_t;
endpackage

// ---- tb/testbench.sv ----
// Self-checking bench for the flash program/erase controller
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module testbench
  import flash_ctrl_pkg::*;
;
  // ----------------------------------------
  // Signals and constants
  // ----------------------------------------
  logic        MCLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, ARRAY_GO, IRQ;
  logic        READ_PROTECT, UNTRUSTED_SOURCE, PROTECT_REMOVE, WAKE_EVENT, FAST_WAKE;
  logic [31:0] PADDR, PWDATA, PRDATA, WRITE_PROTECT, OPTION_STATUS, ARRAY_ADDR, rdat;
  logic [3:0]  ARRAY_OP;
  logic [1:0]  WAIT_STATES;
  logic        rerr;
  int          n_mismatch, samples_checked, n_go;
  logic [31:0] exp_fast_mode_lock;
  localparam logic [31:0] BASE = 32'h00001600;  // Option enable kept, done and error irq on
  localparam logic [31:0] PAGE_ERASE = 32'h2, WHOLE_ARRAY_ERASE = 32'h4, OPTION_AREA_ERASE = 32'h20, START_TRIGGER = 32'h40;
  localparam logic [31:0] FPG = 32'h10000, FER = 32'h20000, BFL = 32'h40000, BCL = 32'h80000;
  localparam logic [31:0] B32 = 32'h800000;

  flash_program_erase_ctrl #(.OP_CYCLES(20)) DUT (
    .MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .READ_PROTECT(READ_PROTECT), .WRITE_PROTECT(WRITE_PROTECT), .OPTION_STATUS(OPTION_STATUS),
    .UNTRUSTED_SOURCE(UNTRUSTED_SOURCE), .PROTECT_REMOVE(PROTECT_REMOVE), .WAKE_EVENT(WAKE_EVENT),
    .FAST_WAKE(FAST_WAKE), .ARRAY_OP(ARRAY_OP), .ARRAY_GO(ARRAY_GO), .ARRAY_ADDR(ARRAY_ADDR),
    .WAIT_STATES(WAIT_STATES), .IRQ(IRQ));

  // Clock and launch pulse counter
  always #25 MCLK = ~MCLK;  // Oscillator kept running through every operation
  always @(posedge MCLK)
    if (ARRAY_GO === 1'b1) n_go++;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until PREADY is sampled high or 20 cycles have passed
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    k = 0;
    do
    begin
      @(posedge MCLK);
      k++;
    end
    while (PREADY !== 1'b1 && k < 20);
    rdat = PRDATA;
    rerr = PSLVERR;
    if (k >= 20)
    begin
      n_mismatch++;
      $display("BAD t=%0t no ready", $time);
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rde(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do
    begin
      apb(1'b0, `ADR_STATUS, 32'h0);
      k++;
    end
    while (rdat[`ST_BUSY] !== 1'b0 && k < 40);
    if (rdat[`ST_BUSY] !== 1'b0)
    begin
      n_mismatch++;
      $display("BAD t=%0t still busy", $time);
    end
  endtask

  task automatic do_reset();
    RESET <= 1'b1;
    repeat (8) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
  endtask

  // Start one operation, judge busy, launch, flags and interrupt
  task automatic run_op(input logic [31:0] c, input logic [3:0] op, input logic [31:0] st);
    int g;
    g = n_go;
    apb(1'b0, `ADR_CONTROL, 32'h0);
    chk({31'h0, rdat[`CT_START_TRIGGER]}, 32'h0);
    wr(`ADR_CONTROL, BASE | c | START_TRIGGER);
    apb(1'b0, `ADR_STATUS, 32'h0);
    chk({31'h0, rdat[`ST_BUSY]}, {31'h0, op != 4'h0});
    chk({28'h0, ARRAY_OP}, {28'h0, op});
    wait_idle();
    chk(rdat & 32'h31, st);
    chk(32'(n_go - g), {31'h0, op != 4'h0});
    chk({31'h0, IRQ}, {31'h0, st != 32'h0});
    if (op != 4'h0)
      rde(`ADR_CONTROL, BASE | c | exp_fast_mode_lock);
    wr(`ADR_STATUS, 32'h30);
    rde(`ADR_STATUS, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rde(`ADR_CONTROL, `CTRL_RESET);
    rde(`ADR_STATUS, 32'h0);
    rde(`ADR_ACCESS, 32'h0);
    rde(`ADR_TADDR, 32'h0);
    rde(`ADR_WPSTAT, 32'hFFFFFFFF);
    rde(`ADR_OBSTAT, 32'h0000A5C3);
    apb(1'b0, 32'h40022018, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_wait();
    for (int i = 0; i < 3; i++)
    begin
      wr(`ADR_ACCESS, 32'(i));
      rde(`ADR_ACCESS, 32'(i));
      chk({30'h0, WAIT_STATES}, 32'(i));
    end
    wr(`ADR_ACCESS, 32'h3);
    rde(`ADR_ACCESS, 32'h2);
    wr(`ADR_ACCESS, 32'h0);
    $display("test wait states done");
  endtask

  task automatic t_lock();
    wr(`ADR_CONTROL, BASE | WHOLE_ARRAY_ERASE | START_TRIGGER);
    rde(`ADR_CONTROL, `CTRL_RESET);
    rde(`ADR_STATUS, 32'h0);
    wr(`ADR_OKEY, `KEY_FIRST);
    wr(`ADR_OKEY, `KEY_SECOND);
    rde(`ADR_CONTROL, `CTRL_RESET);
    wr(`ADR_CKEY, `KEY_FIRST);
    wr(`ADR_CKEY, `KEY_SECOND);
    chk({31'h0, rerr}, 32'h0);
    rde(`ADR_CONTROL, 32'h00008000);
    for (int i = 0; i < 2; i++)
    begin
      wr(`ADR_OKEY, `KEY_FIRST);
      wr(`ADR_OKEY, `KEY_SECOND);
      rde(`ADR_CONTROL, 32'h00008200);
      if (i == 0) wr(`ADR_CONTROL, 32'h0);
      if (i == 0) rde(`ADR_CONTROL, 32'h00008000);
    end
    $display("test lock done");
  endtask

  task automatic t_ops();
    wr(`ADR_TADDR, 32'h08000800);
    run_op(PAGE_ERASE, OP_PAGE, 32'h20);
    run_op(WHOLE_ARRAY_ERASE, OP_MASS, 32'h20);
    run_op(B32, OP_NONE, 32'h0);
    run_op(OPTION_AREA_ERASE, OP_OPTER, 32'h20);
    run_op(FER, OP_NONE, 32'h0);
    $display("test operations done");
  endtask

  task automatic t_prot();
    @(posedge MCLK);
    WRITE_PROTECT <= 32'hFFFFFFFD;
    wr(`ADR_TADDR, 32'h08000F00);
    run_op(PAGE_ERASE, OP_NONE, 32'h10);
    wr(`ADR_TADDR, 32'h08001000);
    run_op(PAGE_ERASE, OP_PAGE, 32'h20);
    WRITE_PROTECT <= 32'hFFFFFFFF;
    READ_PROTECT <= 1'b1;
    wr(`ADR_TADDR, 32'h08000700);
    run_op(PAGE_ERASE, OP_NONE, 32'h10);
    wr(`ADR_TADDR, 32'h08000800);
    run_op(PAGE_ERASE, OP_PAGE, 32'h20);
    UNTRUSTED_SOURCE <= 1'b1;
    run_op(PAGE_ERASE, OP_NONE, 32'h10);
    run_op(WHOLE_ARRAY_ERASE, OP_MASS, 32'h20);
    run_op(OPTION_AREA_ERASE, OP_OPTER, 32'h20);
    READ_PROTECT <= 1'b0;
    UNTRUSTED_SOURCE <= 1'b0;
    PROTECT_REMOVE <= 1'b1;
    @(posedge MCLK);
    PROTECT_REMOVE <= 1'b0;
    repeat (3) @(posedge MCLK);
    chk({28'h0, ARRAY_OP}, {28'h0, OP_MASS});
    wait_idle();
    wr(`ADR_STATUS, 32'h30);
    $display("test protection done");
  endtask

  task automatic t_fast();
    wr(`ADR_FKEY, `KEY_FIRST);
    wr(`ADR_FKEY, `KEY_SECOND);
    apb(1'b0, `ADR_CONTROL, 32'h0);
    chk({31'h0, rdat[`CT_FAST_MODE_LOCK]}, 32'h0);
    exp_fast_mode_lock = 32'h0;
    run_op(FER, OP_FERASE, 32'h20);
    run_op(B32, OP_BLK32, 32'h20);
    run_op(FPG, OP_FPROG, 32'h20);
    run_op(BFL, OP_BFILL, 32'h20);
    run_op(BCL, OP_BCLR, 32'h20);
    exp_fast_mode_lock = 32'h00008000;
    wr(`ADR_CONTROL, BASE | 32'h8000);
    rde(`ADR_CONTROL, BASE | 32'h8000);
    run_op(FPG, OP_NONE, 32'h0);
    $display("test fast mode done");
  endtask

  task automatic t_busy();
    wr(`ADR_TADDR, 32'h08002000);
    wr(`ADR_CONTROL, BASE | PAGE_ERASE | START_TRIGGER);
    wr(`ADR_TADDR, 32'h08003000);
    wr(`ADR_CONTROL, BASE | WHOLE_ARRAY_ERASE | START_TRIGGER);
    chk({28'h0, ARRAY_OP}, {28'h0, OP_PAGE});
    wait_idle();
    rde(`ADR_TADDR, 32'h08002000);
    chk(ARRAY_ADDR, 32'h08002000);
    wr(`ADR_STATUS, 32'h30);
    rde(`ADR_STATUS, 32'h0);
    $display("test busy done");
  endtask

  task automatic t_wake();
    wr(`ADR_CONTROL, BASE | 32'h2000);
    FAST_WAKE <= 1'b1;
    WAKE_EVENT <= 1'b1;
    @(posedge MCLK);
    WAKE_EVENT <= 1'b0;
    rde(`ADR_STATUS, 32'hC0);
    chk({31'h0, IRQ}, 32'h1);
    wr(`ADR_STATUS, 32'h40);
    rde(`ADR_STATUS, 32'hC0);
    wr(`ADR_STATUS, 32'h0);
    rde(`ADR_STATUS, 32'h80);
    chk({31'h0, IRQ}, 32'h0);
    $display("test wake done");
  endtask

  task automatic t_badkey();
    do_reset();
    wr(`ADR_CKEY, 32'h11111111);
    chk({31'h0, rerr}, 32'h1);
    wr(`ADR_CKEY, `KEY_FIRST);
    wr(`ADR_CKEY, `KEY_SECOND);
    chk({31'h0, rerr}, 32'h1);
    rde(`ADR_CONTROL, `CTRL_RESET);
    $display("test bad key done");
  endtask

  // ----------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    MCLK = 1'b0;
    RESET = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {READ_PROTECT, UNTRUSTED_SOURCE, PROTECT_REMOVE, WAKE_EVENT, FAST_WAKE} = '0;
    WRITE_PROTECT = 32'hFFFFFFFF;
    OPTION_STATUS = 32'h0000A5C3;
    n_mismatch = 0;
    samples_checked = 0;
    n_go = 0;
    exp_fast_mode_lock = 32'h00008000;
    do_reset();
    t_reset();
    t_wait();
    t_lock();
    t_ops();
    t_prot();
    t_fast();
    t_busy();
    t_wake();
    t_badkey();
    report_and_stop();
  end

  initial
  begin
    #2000000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
